// file: core/pwg_acc_if.sv
// Carrier between the wait controller and its address decoder
`timescale 1ns/1ps
interface pwg_acc_if #(parameter int ADDR_W = 20);
   logic [ADDR_W-1:0] addr; // Access address
   pwg_pkg::pwg_grp_t grp; // Decoded register group
   logic in_win; // Address lies in the stalling window

   // Decoder side
   modport dec (input addr, output grp, output in_win);
   // Controller side
   modport core (output addr, input grp, input in_win);
endinterface : pwg_acc_if

// file: core/pwg_decode.sv
// Address decoder: maps an access address to its register group
`timescale 1ns/1ps
`include "pwg_map.svh"
module pwg_decode #(
   parameter int ADDR_W = 20
) (
   pwg_acc_if.dec acc
);
   localparam int NGRP = 8;

   // Group range table, index i maps to group code i+1
   localparam logic [19:0] LO [NGRP] = '{`PWG_CLK_LO, `PWG_PORT_LO, `PWG_TMRA_LO,
      `PWG_TMRC_LO, `PWG_PGA_LO, `PWG_CMP_LO, `PWG_LSER_LO, `PWG_MISC_LO};
   localparam logic [19:0] HI [NGRP] = '{`PWG_CLK_HI, `PWG_PORT_HI, `PWG_TMRA_HI,
      `PWG_TMRC_HI, `PWG_PGA_HI, `PWG_CMP_HI, `PWG_LSER_HI, `PWG_MISC_HI};

   // Inclusive range test
   function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo,
                                     input logic [19:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   logic [19:0] a20; // Address normalised to 20 bits
   logic [NGRP-1:0] hit; // One bit per matching group

   assign a20 = acc.addr[19:0];

   // One comparator pair per group
   for (genvar i = 0; i < NGRP; i++) begin : g_hit
      assign hit[i] = in_range(a20, LO[i], HI[i]);
   end

   assign acc.in_win = in_range(a20, `PWG_WIN_LO, `PWG_WIN_HI);

   // Lowest matching group wins; window hits with no group are reserved
   always_comb begin
      acc.grp = acc.in_win ? pwg_pkg::GRP_RSVD : pwg_pkg::GRP_NONE;
      for (int i = NGRP - 1; i >= 0; i--) begin
         if (hit[i]) begin
            acc.grp = pwg_pkg::pwg_grp_t'(4'(i + 1));
         end
      end
   end
endmodule : pwg_decode

// file: core/pwg_map.svh
// Address map, field values and reset values of the wait generator
`ifndef PWG_MAP_SVH
`define PWG_MAP_SVH

// Extended peripheral register window that stalls the CPU
`define PWG_WIN_LO 20'hf0500
`define PWG_WIN_HI 20'hf06ff

// Register group address ranges inside the window
`define PWG_CLK_LO 20'hf0500
`define PWG_CLK_HI 20'hf050f
`define PWG_PORT_LO 20'hf0510
`define PWG_PORT_HI 20'hf051f
`define PWG_TMRA_LO 20'hf0520
`define PWG_TMRA_HI 20'hf05bf
`define PWG_TMRC_LO 20'hf05c0
`define PWG_TMRC_HI 20'hf05df
`define PWG_PGA_LO 20'hf05e0
`define PWG_PGA_HI 20'hf05e3
`define PWG_CMP_LO 20'hf05f0
`define PWG_CMP_HI 20'hf05ff
`define PWG_LSER_LO 20'hf0600
`define PWG_LSER_HI 20'hf063f
`define PWG_MISC_LO 20'hf0640
`define PWG_MISC_HI 20'hf065f

// Location of the pll control register, snooped on CPU writes
`define PWG_PLL_CONTROL_REGISTER_ADDR 20'hf0500
// Pll control value that selects pll-based 32 MHz CPU clock
`define PWG_PLL_32M 8'h0d
// Pll control register value after reset
`define PWG_PLL_RST 8'h00

// Wait clock counts
`define PWG_WAIT_NONE 2'h0
`define PWG_WAIT_ONE 2'h1
`define PWG_WAIT_TWO 2'h2

`endif

// file: core/pwg_pkg.sv
// Types shared by the wait generator modules
package pwg_pkg;

   // Register groups seen by the address decoder
   typedef enum logic [3:0] {
      GRP_NONE = 4'h0,
      GRP_CLK = 4'h1,
      GRP_PORT = 4'h2,
      GRP_TMRA = 4'h3,
      GRP_TMRC = 4'h4,
      GRP_PGA = 4'h5,
      GRP_CMP = 4'h6,
      GRP_LSER = 4'h7,
      GRP_MISC = 4'h8,
      GRP_RSVD = 4'h9
   } pwg_grp_t;

   // Controller states
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } pwg_state_t;

   // Complete state of the top module
   typedef struct packed {
      pwg_state_t st;
      logic [1:0] cnt;
      logic [7:0] pll;
      logic [1:0] last;
      logic done;
   } pwg_regs_t;

endpackage : pwg_pkg

// file: core/pwg_top.sv
// Wait generator for CPU accesses to the extended peripheral register window
//
// Operation
// - Window access stalls CPU until wait ends
// - Instruction grows by exactly inserted wait clocks
// - Every listed register waits on each access
// - Clock and extra port registers wait one
// - Timer group A read waits two at 32MHz
// - Timer group C read waits two at 32MHz
// - Gain amplifier read waits two at 32MHz
// - Comparator read waits two at 32MHz
// - Lighting serial unit always waits one clock
`timescale 1ns/1ps
`include "pwg_map.svh"
module pwg_top #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic acc_req_i,
   input wire logic acc_wr_i,
   input wire logic [ADDR_W-1:0] acc_addr_i,
   input wire logic [DATA_W-1:0] acc_wdata_i,
   output logic cpu_wait_o,
   output logic acc_done_o,
   output logic [1:0] last_wait_o,
   output logic pll_32m_o
);

   // Decoder ranges are fixed 20-bit addresses
   if (ADDR_W != 20) begin : g_bad_addr_w
      $error("ADDR_W must be 20");
   end
   // Pll snoop needs a full byte of write data
   if (DATA_W < 8) begin : g_bad_data_w
      $error("DATA_W must be at least 8");
   end

   pwg_pkg::pwg_regs_t q; // Registered state
   pwg_pkg::pwg_regs_t d; // Next state
   logic pll32; // Pll control holds the 32 MHz setting
   logic [1:0] need; // Wait clocks required by the current request
   logic take; // Request accepted this cycle

   pwg_acc_if #(.ADDR_W(ADDR_W)) acc ();

   assign acc.addr = acc_addr_i;

   // Address decoder
   pwg_decode #(.ADDR_W(ADDR_W)) u_dec (
      .acc(acc)
   );

   // Wait clocks for a group, direction and clock setting
   function automatic logic [1:0] wait_count(input pwg_pkg::pwg_grp_t g, input logic wr,
                                             input logic p32);
      case (g)
         // Pll dependent reads, writes always one
         pwg_pkg::GRP_TMRA, pwg_pkg::GRP_TMRC,
         pwg_pkg::GRP_PGA, pwg_pkg::GRP_CMP: begin
            wait_count = (!wr && p32) ? `PWG_WAIT_TWO : `PWG_WAIT_ONE;
         end
         // Fixed one clock groups
         pwg_pkg::GRP_CLK, pwg_pkg::GRP_PORT: begin
            wait_count = `PWG_WAIT_ONE;
         end
         pwg_pkg::GRP_LSER: begin
            wait_count = `PWG_WAIT_ONE;
         end
         pwg_pkg::GRP_MISC, pwg_pkg::GRP_RSVD: begin
            wait_count = `PWG_WAIT_ONE;
         end
         // Outside the window
         default: begin
            wait_count = `PWG_WAIT_NONE;
         end
      endcase
   endfunction : wait_count

   assign pll32 = (q.pll == `PWG_PLL_32M);
   assign need = wait_count(acc.grp, acc_wr_i, pll32);
   assign take = acc_req_i && (q.st == pwg_pkg::ST_IDLE);

   // Next state logic
   always_comb begin
      d = q;
      d.done = 1'b0;
      // Snoop CPU writes to the pll control register
      if (take && acc_wr_i && (acc_addr_i[19:0] == `PWG_PLL_CONTROL_REGISTER_ADDR)) begin
         d.pll = acc_wdata_i[7:0];
      end
      case (q.st)
         pwg_pkg::ST_IDLE: begin
            if (take) begin
               d.last = need;
               if (need == `PWG_WAIT_NONE) begin
                  d.done = 1'b1;
               end else begin
                  d.st = pwg_pkg::ST_WAIT;
                  d.cnt = need;
               end
            end
         end
         pwg_pkg::ST_WAIT: begin
            // Count down exactly the required wait clocks
            d.cnt = q.cnt - 2'h1;
            if (q.cnt == `PWG_WAIT_ONE) begin
               d.st = pwg_pkg::ST_IDLE;
               d.done = 1'b1;
            end
         end
         default: begin
            d.st = pwg_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q.st <= pwg_pkg::ST_IDLE;
         q.cnt <= `PWG_WAIT_NONE;
         q.pll <= `PWG_PLL_RST;
         q.last <= `PWG_WAIT_NONE;
         q.done <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // Stall output holds the CPU while waits remain
   assign cpu_wait_o = (q.st == pwg_pkg::ST_WAIT);
   assign acc_done_o = q.done;
   assign last_wait_o = q.last;
   assign pll_32m_o = pll32;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_one;
      cpu_wait_o ##1 !cpu_wait_o;
   endsequence

   sequence s_two;
      cpu_wait_o [*2] ##1 !cpu_wait_o;
   endsequence

   a_window_stall: assert property (take && acc.in_win |=> cpu_wait_o)
      else $error("window access did not stall the CPU");

   a_wait_length: assert property (take && need == 2'h2 |=> s_two ##0 acc_done_o)
      else $error("wait length differs from required count");

   a_listed_waits: assert property (take && acc.grp != pwg_pkg::GRP_NONE |=> cpu_wait_o)
      else $error("listed register access raised no wait");

   // Fixed one clock groups
   a_clk_port_one: assert property (take && (acc.grp == pwg_pkg::GRP_CLK ||
      acc.grp == pwg_pkg::GRP_PORT) |=> s_one)
      else $error("clock or port access not one wait");

   // Pll dependent groups: reads stretch at 32 MHz, writes stay at one
   a_tmra_read_two: assert property (take && acc.grp == pwg_pkg::GRP_TMRA
      && !acc_wr_i && q.pll == 8'h0d |=> s_two)
      else $error("timer group A read at 32MHz not two waits");

   a_tmra_write_one: assert property (take && acc.grp == pwg_pkg::GRP_TMRA
      && acc_wr_i |=> s_one)
      else $error("timer group A write not one wait");

   a_tmrc_read_one: assert property (take && acc.grp == pwg_pkg::GRP_TMRC
      && !acc_wr_i && q.pll != 8'h0d |=> s_one)
      else $error("timer group C read not one wait");

   a_tmrc_read_two: assert property (take && acc.grp == pwg_pkg::GRP_TMRC
      && !acc_wr_i && pll_32m_o |=> s_two)
      else $error("timer group C read at 32MHz not two waits");

   a_pga_write_one: assert property (take && acc.grp == pwg_pkg::GRP_PGA
      && acc_wr_i |=> s_one)
      else $error("gain amplifier write not one wait");

   a_pga_read_two: assert property (take && acc.grp == pwg_pkg::GRP_PGA
      && !acc_wr_i && pll_32m_o |=> s_two)
      else $error("gain amplifier read at 32MHz not two waits");

   a_cmp_read_two: assert property (take && acc.grp == pwg_pkg::GRP_CMP
      && !acc_wr_i && pll_32m_o |=> s_two)
      else $error("comparator read at 32MHz not two waits");

   a_cmp_write_one: assert property (take && acc.grp == pwg_pkg::GRP_CMP
      && acc_wr_i |=> s_one)
      else $error("comparator write not one wait");

   // Lighting serial unit ignores the clock setting
   a_lser_one: assert property (take && acc.grp == pwg_pkg::GRP_LSER |=> s_one)
      else $error("lighting serial access not one wait");

   // Addresses outside the window finish at once
   a_no_wait: assert property (take && acc.grp == pwg_pkg::GRP_NONE
      |=> !cpu_wait_o && acc_done_o && last_wait_o == 2'h0)
      else $error("unlisted access inserted a wait");

   // Single wait ends with the done pulse in the following cycle
   a_one_done: assert property (take && need == 2'h1 |=> s_one ##0 acc_done_o)
      else $error("one wait access did not finish on time");

   // Recorded count matches the count granted at the taking edge
   a_last_count: assert property (take |=> last_wait_o == $past(need))
      else $error("recorded wait count differs from granted count");

   // Done never overlaps a stall
   a_done_free: assert property (acc_done_o |-> !cpu_wait_o)
      else $error("done raised while the CPU is stalled");

   // Requests during a stall leave count and pll state alone
   a_busy_ignored: assert property (cpu_wait_o |=> $stable(last_wait_o)
      && $stable(pll_32m_o))
      else $error("request during a stall was accepted");

endmodule : pwg_top

// file: test/pwg_cpu_model.sv
// CPU model that issues peripheral register reads and writes
`timescale 1ns/1ps
module pwg_cpu_model (
   input wire logic clk_i,
   input wire logic done_i,
   output logic req_o,
   output logic wr_o,
   output logic [19:0] addr_o,
   output logic [7:0] wdata_o
);
   // Idle bus at time zero
   initial begin
      req_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 20'h00000;
      wdata_o = 8'h00;
   end

   // One access; called at a rising edge, returns at a rising edge
   task automatic access(input logic wr, input logic [19:0] addr, input logic [7:0] wdata,
                         input logic poke);
      int k;
      k = 0;
      req_o <= 1'b1;
      wr_o <= wr;
      addr_o <= addr;
      wdata_o <= wdata;
      @(posedge clk_i);
      // Optional request during the stall, which the block must ignore
      req_o <= poke;
      // Released lines show the inverse so stale values are never trusted
      addr_o <= ~addr;
      wr_o <= ~wr;
      wdata_o <= ~wdata;
      #1;
      while (done_i !== 1'b1 && k < 16) begin
         @(posedge clk_i);
         req_o <= 1'b0;
         #1;
         k++;
      end
      @(posedge clk_i);
   endtask : access
endmodule : pwg_cpu_model

// file: test/testbench.sv
// Self-checking bench for the peripheral access wait generator
`timescale 1ns/1ps
`include "pwg_map.svh"
module testbench;
   logic clk_i, rst_n_i, acc_req, acc_wr; // Clock, reset and request lines
   logic [19:0] acc_addr; // Access address
   logic [7:0] acc_wdata; // Write data
   logic cpu_wait_o, acc_done_o, pll_32m_o; // Block outputs
   logic [1:0] last_wait_o; // Wait count of last access
   logic [2:0] exp_q[$]; // Expected {pll flag, waits}
   logic [2:0] e; // Popped note
   logic [7:0] pll; // Bench copy of pll control
   logic [31:0] seed; // Random state
   logic [3:0] wait_cnt; // Measured stall cycles
   int failures, checks, cycles;
   logic [19:0] tbl[17] = '{20'hf050f, 20'hf0510, 20'hf0520, 20'hf05bf, 20'hf05c0, 20'hf05df,
      20'hf05e0, 20'hf05e3, 20'hf05e8, 20'hf05f0, 20'hf05ff, 20'hf0600, 20'hf063f, 20'hf0660,
      20'hf06ff, 20'hf04ff, 20'hf0700};

   pwg_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .acc_req_i(acc_req), .acc_wr_i(acc_wr),
      .acc_addr_i(acc_addr), .acc_wdata_i(acc_wdata), .cpu_wait_o(cpu_wait_o),
      .acc_done_o(acc_done_o), .last_wait_o(last_wait_o), .pll_32m_o(pll_32m_o));
   pwg_cpu_model i_cpu (.clk_i(clk_i), .done_i(acc_done_o), .req_o(acc_req), .wr_o(acc_wr),
      .addr_o(acc_addr), .wdata_o(acc_wdata));

   // Clock at 4 ns period
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // Wait count that an access should receive
   function automatic logic [1:0] exp_wait(logic wr, logic [19:0] a, logic [7:0] p);
      if (a < `PWG_WIN_LO || a > `PWG_WIN_HI) return 2'h0;
      if (!wr && p == `PWG_PLL_32M && ((a >= `PWG_TMRA_LO && a <= `PWG_PGA_HI) ||
          (a >= `PWG_CMP_LO && a <= `PWG_CMP_HI))) return 2'h2;
      return 2'h1;
   endfunction : exp_wait

   // Xorshift step
   function automatic logic [31:0] xs(logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // Compare one result
   task automatic chk(input logic [3:0] exp, input logic [3:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk

   // Note the expectation, then let the CPU model issue the access
   task automatic run(input logic wr, input logic [19:0] a, input logic [7:0] d, input logic pk);
      logic [1:0] n;
      n = exp_wait(wr, a, pll);
      if (wr && a == `PWG_PLL_CONTROL_REGISTER_ADDR) pll = d;
      exp_q.push_back({pll == `PWG_PLL_32M, n});
      i_cpu.access(wr, a, d, pk && n != 2'h0);
   endtask : run

   // Verdict and end of run
   task automatic test_done();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done

   // Watcher: counts stall cycles, checks each completed access
   always @(posedge clk_i) begin
      if (rst_n_i === 1'b1 && acc_done_o === 1'b1) begin
         if (exp_q.size() == 0) chk(4'h0, 4'hf);
         else begin
            e = exp_q.pop_front();
            chk({2'h0, e[1:0]}, wait_cnt);
            chk({2'h0, e[1:0]}, {2'h0, last_wait_o});
            chk({3'h0, e[2]}, {3'h0, pll_32m_o});
         end
         wait_cnt = 4'h0;
      end else if (cpu_wait_o === 1'b1) wait_cnt++;
   end

   // Hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         test_done();
      end
   end

   // Main sequence
   initial begin
      rst_n_i = 1'b0;
      pll = `PWG_PLL_RST;
      seed = 32'd20;
      wait_cnt = 4'h0;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      chk(4'h0, {cpu_wait_o, acc_done_o, last_wait_o});
      chk(4'h0, {3'h0, pll_32m_o});
      foreach (tbl[i]) begin
         run(1'b0, tbl[i], 8'h00, 1'b1);
         run(1'b1, tbl[i], 8'h5a, 1'b0);
      end
      run(1'b1, `PWG_PLL_CONTROL_REGISTER_ADDR, `PWG_PLL_32M, 1'b1);
      foreach (tbl[i]) begin
         run(1'b0, tbl[i], 8'h00, 1'b0);
         run(1'b1, tbl[i], 8'ha5, 1'b1);
      end
      run(1'b1, `PWG_PLL_CONTROL_REGISTER_ADDR, 8'h0c, 1'b0);
      run(1'b0, `PWG_TMRA_LO, 8'h00, 1'b1);
      repeat (80) begin
         seed = xs(seed);
         run(seed[10], 20'hf0400 + {10'h0, seed[9:0]}, seed[11] ? 8'h0d : seed[19:12],
             seed[12]);
      end
      run(1'b1, `PWG_PLL_CONTROL_REGISTER_ADDR, `PWG_PLL_32M, 1'b0);
      repeat (2) @(posedge clk_i);
      // Mid-run reset must clear the snooped pll setting
      rst_n_i <= 1'b0;
      pll = `PWG_PLL_RST;
      repeat (2) @(posedge clk_i);
      chk(4'h0, {cpu_wait_o, acc_done_o, last_wait_o});
      chk(4'h0, {3'h0, pll_32m_o});
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      run(1'b0, `PWG_TMRA_LO, 8'h00, 1'b1);
      repeat (4) @(posedge clk_i);
      chk(4'h0, {3'h0, exp_q.size() != 0});
      test_done();
   end
endmodule : testbench
